// File: rtl/cfg_loader_pkg.sv
// Purpose: constants for the configuration word one loader
// Assumes: program flash answers a word read with a fixed latency
// Notes: word address is in program address units
// Behaviour
// [R1] every reset reloads all configuration latches from flash before operation resumes; the loader fetches only word one, word two is not read
// [R2] word one fetched from top program address, word two two units below
// [R3] programmer should fill upper byte of both words with ones
// [R4] upper byte and bit 5 read back as one; writes there do nothing
// [R5] programmer writes zero to reserved bit 15
// [R6] bit 14 one enables the boundary-scan port, zero disables it
// [R7] bit 13 zero protects the whole program memory
// [R8] bit 12 zero blocks program memory writes
// [R9] bit 11 zero starts in background debug mode, one operational
// [R10] programmer keeps reserved bit 10 at one
// [R11] bits 9-8 route emulator pins: 11 pair1, 10 pair2, 01 pair3, 00 reserved
// [R12] bit 7 one runs the watchdog, zero disables it
// [R13] bit 6 zero selects windowed watchdog, which needs bit 7 set
// [R14] bit 4 one selects prescale 128, zero selects 32
// [R15] bits 3-0 give postscale two to the field value
// [R16] fields program once and read as one while unprogrammed
// [R17] application should reserve the configuration word addresses
// [R18] packed flash data copied into distributed latches during each reset
// [R19] loaded values hold steady until next reset; run-time writes ignored
package cfg_loader_pkg;
  localparam int ADDR_W = 24;
  localparam int WORD_W = 24;
  localparam logic [ADDR_W-1:0] WORD_ONE_ADDR = 24'h00ABFE;
  localparam logic [ADDR_W-1:0] WORD_TWO_STEP = 24'h000002;
  localparam logic [WORD_W-1:0] UNPROG_WORD = 24'hFFFFFF;
  localparam logic [WORD_W-1:0] FORCE_ONE_MASK = 24'hFF0020;
  localparam int POS_SCAN = 14;
  localparam int POS_CODE_PROT = 13;
  localparam int POS_WRITE_PROT = 12;
  localparam int POS_DEBUG = 11;
  localparam int POS_EMU_HI = 9;
  localparam int POS_EMU_LO = 8;
  localparam int POS_WDT_ON = 7;
  localparam int POS_WIN_OFF = 6;
  localparam int POS_PRESCALE = 4;
  localparam int POS_POST_HI = 3;
  localparam int POS_POST_LO = 0;
  localparam logic [1:0] EMU_PAIR1 = 2'h3;
  localparam logic [1:0] EMU_PAIR2 = 2'h2;
  localparam logic [1:0] EMU_PAIR3 = 2'h1;
  localparam logic [7:0] PRESCALE_HI = 8'h80;
  localparam logic [7:0] PRESCALE_LO = 8'h20;
  localparam int READ_LAT = 2;
  typedef enum logic [1:0] {ST_REQ, ST_WAIT, ST_DONE} load_state_t;
endpackage

// File: rtl/cfg_field_decode.sv
// Purpose: decode latched configuration word one into control outputs
// Assumes: word already has unimplemented bits forced to one
// Notes: purely combinational
module cfg_field_decode
  import cfg_loader_pkg::*;
(
  input wire logic [WORD_W-1:0] word_i,
  output logic boundary_scan_port_on_o,
  output logic code_protect_on_o,
  output logic program_write_block_o,
  output logic debug_mode_o,
  output logic [2:0] emulator_pair_onehot_o,
  output logic emulator_sel_reserved_o,
  output logic watchdog_on_o,
  output logic watchdog_window_o,
  output logic [7:0] watchdog_prescale_o,
  output logic [15:0] watchdog_postscale_o
);
  wire [1:0] emulator_pin_pair_sel = word_i[POS_EMU_HI:POS_EMU_LO];
  wire [3:0] watchdog_postscale_sel = word_i[POS_POST_HI:POS_POST_LO];
  assign boundary_scan_port_on_o = word_i[POS_SCAN]; // R6
  assign code_protect_on_o = ~word_i[POS_CODE_PROT]; // R7
  assign program_write_block_o = ~word_i[POS_WRITE_PROT]; // R8
  assign debug_mode_o = ~word_i[POS_DEBUG]; // R9
  assign emulator_pair_onehot_o = {emulator_pin_pair_sel == EMU_PAIR3,
                                   emulator_pin_pair_sel == EMU_PAIR2,
                                   emulator_pin_pair_sel == EMU_PAIR1}; // R11
  assign emulator_sel_reserved_o = (emulator_pin_pair_sel == 2'h0); // R11
  assign watchdog_on_o = word_i[POS_WDT_ON]; // R12
  // windowed only counts when the watchdog runs at all
  assign watchdog_window_o = ~word_i[POS_WIN_OFF] & word_i[POS_WDT_ON]; // R13
  assign watchdog_prescale_o = word_i[POS_PRESCALE] ? PRESCALE_HI : PRESCALE_LO; // R14
  // output holds the power-of-two exponent decode minus one: ratio = value + 1
  assign watchdog_postscale_o = 16'((17'h1 << watchdog_postscale_sel) - 17'h1); // R15
endmodule

// File: rtl/flash_config_word_one_loader.sv
// Purpose: fetch configuration word one from program flash at every reset and hold it
// Assumes: flash read data valid READ_LAT cycles after a read strobe
// Notes: any reset source must drive rst_b_i low
module flash_config_word_one_loader
  import cfg_loader_pkg::*;
#(
  parameter logic [ADDR_W-1:0] TOP_WORD_ADDR = WORD_ONE_ADDR
) (
  input wire logic core_clk_i,
  input wire logic rst_b_i,
  input wire logic clk_en_i,
  output logic flash_rd_o,
  output logic [ADDR_W-1:0] flash_addr_o,
  input wire logic [WORD_W-1:0] flash_rdata_i,
  output logic load_done_o,
  output logic [ADDR_W-1:0] word_two_addr_o,
  output logic [WORD_W-1:0] config_word_one_o,
  output logic boundary_scan_port_on_o,
  output logic code_protect_on_o,
  output logic program_write_block_o,
  output logic debug_mode_o,
  output logic [2:0] emulator_pair_onehot_o,
  output logic emulator_sel_reserved_o,
  output logic watchdog_on_o,
  output logic watchdog_window_o,
  output logic [7:0] watchdog_prescale_o,
  output logic [15:0] watchdog_postscale_o
);
  ////////////////////////////////////////////////////////////////////////
  logic rst_meta_b;
  logic rst_sync_b;
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rst_meta_b <= 1'b0;
      rst_sync_b <= 1'b0;
    end else begin
      rst_meta_b <= 1'b1;
      rst_sync_b <= rst_meta_b;
    end
  end
  ////////////////////////////////////////////////////////////////////////
  load_state_t state;
  load_state_t next_state;
  logic [1:0] wait_cnt;
  logic [WORD_W-1:0] config_word_one;
  wire wait_over = (wait_cnt == 2'(READ_LAT - 1));
  wire capture = (state == ST_WAIT) && wait_over;
  always_comb begin
    next_state = state;
    unique case (state)
      ST_REQ: next_state = ST_WAIT;
      ST_WAIT: if (wait_over) next_state = ST_DONE;
      ST_DONE: next_state = ST_DONE;
    endcase
  end
  // every reset restarts the fetch, latches go unprogrammed meanwhile
  always_ff @(posedge core_clk_i or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      state <= ST_REQ; // R1 R18
      wait_cnt <= 2'h0;
      config_word_one <= UNPROG_WORD; // R16
    end else if (clk_en_i) begin
      state <= next_state;
      wait_cnt <= (state == ST_WAIT) ? wait_cnt + 2'h1 : 2'h0;
      // only written once per reset; nothing else can write it
      if (capture) config_word_one <= flash_rdata_i | FORCE_ONE_MASK; // R4 R18 R19
    end
  end
  assign flash_rd_o = (state == ST_REQ);
  assign flash_addr_o = TOP_WORD_ADDR; // R2
  assign word_two_addr_o = TOP_WORD_ADDR - WORD_TWO_STEP; // R2
  assign load_done_o = (state == ST_DONE); // R1
  assign config_word_one_o = config_word_one;
  ////////////////////////////////////////////////////////////////////////
  cfg_field_decode u_decode (
    .word_i(config_word_one),
    .boundary_scan_port_on_o(boundary_scan_port_on_o),
    .code_protect_on_o(code_protect_on_o),
    .program_write_block_o(program_write_block_o),
    .debug_mode_o(debug_mode_o),
    .emulator_pair_onehot_o(emulator_pair_onehot_o),
    .emulator_sel_reserved_o(emulator_sel_reserved_o),
    .watchdog_on_o(watchdog_on_o),
    .watchdog_window_o(watchdog_window_o),
    .watchdog_prescale_o(watchdog_prescale_o),
    .watchdog_postscale_o(watchdog_postscale_o)
  );
endmodule

// File: test/cfg_loader_asserts.sv
// Purpose: port checks for the configuration word loader
// Assumes: clk_en_i may drop during a fetch; the checks sample it
// Notes: bound to the loader top
module cfg_loader_asserts #(parameter logic [23:0] TOP_WORD_ADDR = 24'h00ABFE) (
  input wire logic core_clk_i,
  input wire logic rst_b_i,
  input wire logic clk_en_i,
  input wire logic flash_rd_o,
  input wire logic load_done_o,
  input wire logic [23:0] flash_addr_o,
  input wire logic [23:0] word_two_addr_o,
  input wire logic [23:0] flash_rdata_i,
  input wire logic [23:0] config_word_one_o,
  input wire logic boundary_scan_port_on_o,
  input wire logic code_protect_on_o,
  input wire logic watchdog_window_o
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!rst_b_i);
  sequence s_fetch;
    flash_rd_o ##1 !flash_rd_o && clk_en_i ##1 clk_en_i;
  endsequence
  AST_ADDR: assert property (flash_addr_o == TOP_WORD_ADDR && word_two_addr_o == TOP_WORD_ADDR - 24'h2)
    else $error("bad address");
  AST_LOAD: assert property (s_fetch |=> load_done_o) else $error("late load");
  AST_ONE_READ: assert property (load_done_o |-> !flash_rd_o) else $error("read after load");
  AST_CAPTURE: assert property ($rose(load_done_o) |-> config_word_one_o == ($past(flash_rdata_i) | 24'hFF0020))
    else $error("bad capture");
  AST_HOLD: assert property (load_done_o |=> load_done_o && $stable(config_word_one_o)) else $error("word moved");
  AST_FREEZE: assert property (!clk_en_i |=> $stable(load_done_o) && $stable(config_word_one_o))
    else $error("moved while clock enable low");
  AST_FORCE: assert property (&config_word_one_o[23:16] && config_word_one_o[5]) else $error("bad fixed bits");
  AST_SCAN: assert property (boundary_scan_port_on_o == config_word_one_o[14]) else $error("bad scan");
  AST_PROT: assert property (code_protect_on_o != config_word_one_o[13]) else $error("bad protect");
  AST_WIN: assert property (watchdog_window_o == (config_word_one_o[7] && !config_word_one_o[6]))
    else $error("bad window");
endmodule
bind flash_config_word_one_loader cfg_loader_asserts #(.TOP_WORD_ADDR(TOP_WORD_ADDR)) cfg_loader_asserts_i (.*);

// File: test/flash_cfg_model.sv
// Purpose: program flash read model
// Assumes: data valid two enabled cycles after the strobe
// Notes: outside those slots, or away from the configuration address, the data toggles
module flash_cfg_model (
  input wire logic core_clk_i,
  input wire logic clk_en_i,
  input wire logic rd_i,
  input wire logic [23:0] addr_i,
  input wire logic [23:0] word_i,
  output logic [23:0] rdata_o
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [1:0] age;
  logic [23:0] junk = 24'h5A5A5A;
  always @(posedge core_clk_i) begin
    junk <= ~junk;
    if (rd_i) age <= 2'h1;
    else if (clk_en_i && age != 2'h0) age <= age + 2'h1;
  end
  // only the reserved top word holds configuration data, never program code
  localparam logic [23:0] CFG_ADDR = 24'h00ABFE;
  wire cfg_hit = (addr_i == CFG_ADDR);
  assign rdata_o = ((age == 2'h1 || age == 2'h2) && cfg_hit) ? word_i : junk;
endmodule

// File: test/flash_config_word_one_loader_tb.sv
// Purpose: reload and decode checks across many resets
// Assumes: default top word address
// Notes: words come from an lfsr with a few fixed corners
module flash_config_word_one_loader_tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic core_clk_i = 0, rst_b_i = 0, clk_en_i = 1, flash_rd_o, load_done_o, boundary_scan_port_on_o;
  logic code_protect_on_o, program_write_block_o, debug_mode_o, emulator_sel_reserved_o, watchdog_on_o;
  logic watchdog_window_o;
  logic [23:0] flash_addr_o, flash_rdata_i, word_two_addr_o, config_word_one_o, word = 24'h0, seed;
  logic [2:0] emulator_pair_onehot_o;
  logic [7:0] watchdog_prescale_o;
  logic [15:0] watchdog_postscale_o;
  int n_errors = 0, check_count = 0;
  flash_config_word_one_loader flash_config_word_one_loader_i (.*);
  flash_cfg_model flash_cfg_model_i (.core_clk_i, .clk_en_i, .rd_i(flash_rd_o), .addr_i(flash_addr_o),
    .word_i(word), .rdata_o(flash_rdata_i));
  initial forever #5 core_clk_i = ~core_clk_i;
  ////////////////////////////////////////
  function automatic logic [23:0] lfsr(logic [23:0] s);
    return {s[22:0], s[23] ^ s[22] ^ s[21] ^ s[16]};
  endfunction
  // programmer side: fixed ones, reserved bit 15 zero and bit 10 one, window only with watchdog on
  function automatic logic [23:0] legal(logic [23:0] w);
    return {8'hFF, 1'b0, w[14:11], 1'b1, w[9:7], w[6] | ~w[7], w[5:0]};
  endfunction
  function automatic logic [33:0] expd(logic [23:0] w);
    return {w[14], ~w[13], ~w[12], ~w[11], w[9:8] == 2'h1, w[9:8] == 2'h2, w[9:8] == 2'h3, w[9:8] == 2'h0,
      w[7], w[7] & ~w[6], w[4] ? 8'h80 : 8'h20, 16'((32'h1 << w[3:0]) - 32'h1)};
  endfunction
  task automatic check(string what, logic [63:0] exp, logic [63:0] got);
    check_count++;
    if (got !== exp) begin
      n_errors++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic load(logic [23:0] w, bit gate);
    int k;
    @(posedge core_clk_i);
    word <= w;
    rst_b_i <= 1'b0;
    clk_en_i <= 1'b1;
    repeat (4) @(posedge core_clk_i);
    check("blank", {2'b01, 24'hFFFFFF}, {load_done_o, flash_rd_o, config_word_one_o});
    rst_b_i <= 1'b1;
    k = 0;
    // gated runs drop the clock enable at random to stretch the fetch
    while (load_done_o !== 1'b1 && k < 60) begin
      @(posedge core_clk_i);
      seed = lfsr(seed);
      clk_en_i <= ~gate | seed[0];
      @(negedge core_clk_i);
      k++;
    end
    if (load_done_o !== 1'b1) begin
      n_errors++;
      end_of_test;
    end
    // two sync edges, one request cycle, two read-latency cycles
    if (!gate) check("latency", 64'd5, 64'(k));
    check("addr", {24'h00ABFE, 24'h00ABFC}, {flash_addr_o, word_two_addr_o});
    check("word", w | 24'hFF0020, config_word_one_o);
    check("fields", expd(w), {boundary_scan_port_on_o, code_protect_on_o, program_write_block_o, debug_mode_o,
      emulator_pair_onehot_o, emulator_sel_reserved_o, watchdog_on_o, watchdog_window_o, watchdog_prescale_o,
      watchdog_postscale_o});
    repeat (4) @(negedge core_clk_i);
    check("hold", w | 24'hFF0020, config_word_one_o);
  endtask
  initial begin
    seed = 24'h00004C;
    for (int i = 0; i < 14; i++) begin
      seed = lfsr(seed);
      if (i == 6) begin
        // cut a fetch mid-way: the next reset must start it afresh
        @(posedge core_clk_i);
        rst_b_i <= 1'b0;
        repeat (4) @(posedge core_clk_i);
        rst_b_i <= 1'b1;
        repeat (3) @(posedge core_clk_i);
        @(negedge core_clk_i);
        check("cut", 64'h0, load_done_o);
      end
      load(legal(i < 4 ? {seed[23:10], i[1:0], seed[7:0]} : (i == 4 ? 24'h000000 : seed)), i > 4 && i[0]);
      $display("test %0d done", i);
    end
    end_of_test;
  end
endmodule
